// ===== rtl/ips_cfg.svh
// ips_cfg.svh: register offsets, field positions, reset values and bus codes
// assumes: included by ips_top and the bench; ips_pkg, ips_sync and ips_chan do not include it
`ifndef IPS_CFG_SVH
`define IPS_CFG_SVH
`define IPS_ADDR_W 4
`define IPS_DATA_W 32
`define IPS_OFF_CTRL 4'h0
`define IPS_OFF_SET 4'h4
`define IPS_OFF_STAT 4'h8
`define IPS_CTRL_MODE_BIT 0
`define IPS_SET_THIRD_LSB 0
`define IPS_SET_FOURTH_LSB 2
`define IPS_SET_FIELD_W 2
`define IPS_STAT_LVL_LSB 0
`define IPS_STAT_SEL_LSB 2
`define IPS_CTRL_RST 1'h0
`define IPS_SET_RST 2'h0
`define IPS_RESP_OKAY 2'h0
`define IPS_RESP_SLVERR 2'h2
`endif

// ===== rtl/ips_pkg.sv
// ips_pkg: types and the polarity decode shared by the input channels
// assumes: nothing from ips_cfg.svh; the enum values are written out in this package
package ips_pkg;

    typedef enum logic [1:0] {
        IPS_BEH_CLOSED = 2'h0,
        IPS_BEH_OPEN = 2'h1,
        IPS_BEH_ON = 2'h2,
        IPS_BEH_OFF = 2'h3
    } ips_beh_e;

    typedef enum logic {
        IPS_MODE_PROG = 1'h0,
        IPS_MODE_JOG = 1'h1
    } ips_mode_e;

    typedef logic [1:0] ips_resp_t;

    // level is high while the contact is closed
    function automatic logic ips_active(input ips_beh_e beh, input logic level);
        logic act;
        act = 1'h0;
        unique case (beh)
            IPS_BEH_CLOSED: act = level;
            IPS_BEH_OPEN: act = ~level;
            IPS_BEH_ON: act = 1'h1;
            IPS_BEH_OFF: act = 1'h0;
        endcase
        return act;
    endfunction : ips_active

endpackage : ips_pkg

// ===== rtl/ips_sync.sv
// ips_sync: three-stage synchroniser for one contact input
// assumes: pin is asynchronous to aclk; level moves only once stages two and three agree
`timescale 1ns/1ps
module ips_sync (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic pin,
    output logic level
);
    logic meta_q;
    logic s2_q;
    logic s3_q;
    logic level_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_q <= 1'h0;
            s2_q <= 1'h0;
            s3_q <= 1'h0;
            level_q <= 1'h0;
        end else begin
            meta_q <= pin;
            s2_q <= meta_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                level_q <= s3_q;
            end
        end
    end

    assign level = level_q;

endmodule : ips_sync

// ===== rtl/ips_chan.sv
// ips_chan: applies one behaviour setting and routes the result by mode
// assumes: level is already synchronised to aclk
`timescale 1ns/1ps
module ips_chan
    import ips_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic level,
    input wire ips_beh_e beh,
    input wire ips_mode_e mode,
    output logic prog_bit,
    output logic jog_bit
);
    logic act;
    logic prog_q;
    logic jog_q;

    assign act = ips_active(beh, level);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prog_q <= 1'h0;
            jog_q <= 1'h0;
        end else begin
            prog_q <= act & (mode == IPS_MODE_PROG);
            jog_q <= act & (mode == IPS_MODE_JOG);
        end
    end

    assign prog_bit = prog_q;
    assign jog_bit = jog_q;

endmodule : ips_chan

// ===== rtl/ips_top.sv
// ips_top: AXI4-Lite slave holding mode and behaviour settings, two input channels
// assumes: one aclk, synchronous active-low aresetn, contacts asynchronous to aclk
`timescale 1ns/1ps
`include "ips_cfg.svh"
module ips_top
    import ips_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [`IPS_ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [`IPS_DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`IPS_ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [`IPS_DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic third_input_pin,
    input wire logic fourth_input_pin,
    output logic program_table_bit_c,
    output logic program_table_bit_d,
    output logic jog_speed_table_bit_b,
    output logic jog_speed_table_bit_c
);
    // write channel state
    logic awready_q;
    logic awready_d;
    logic wready_q;
    logic wready_d;
    logic aw_hold_q;
    logic aw_hold_d;
    logic w_hold_q;
    logic w_hold_d;
    logic [`IPS_ADDR_W-1:0] awaddr_q;
    logic [`IPS_ADDR_W-1:0] awaddr_d;
    logic [`IPS_DATA_W-1:0] wdata_q;
    logic [`IPS_DATA_W-1:0] wdata_d;
    logic [3:0] wstrb_q;
    logic [3:0] wstrb_d;
    logic bvalid_q;
    logic bvalid_d;
    ips_resp_t bresp_q;
    ips_resp_t bresp_d;

    // read channel state
    logic arready_q;
    logic arready_d;
    logic rvalid_q;
    logic rvalid_d;
    logic [`IPS_DATA_W-1:0] rdata_q;
    logic [`IPS_DATA_W-1:0] rdata_d;
    ips_resp_t rresp_q;
    ips_resp_t rresp_d;

    // settings
    ips_mode_e mode_q;
    ips_mode_e mode_d;
    ips_beh_e third_q;
    ips_beh_e third_d;
    ips_beh_e fourth_q;
    ips_beh_e fourth_d;

    logic [1:0] lvl;

    wire logic aw_take;
    wire logic w_take;
    wire logic aw_have;
    wire logic w_have;
    wire logic do_write;
    wire logic [`IPS_ADDR_W-1:0] wr_addr;
    wire logic [`IPS_DATA_W-1:0] wr_data;
    wire logic [3:0] wr_strb;
    wire logic wr_ctrl;
    wire logic wr_set;
    wire logic ar_take;
    wire logic rd_ctrl;
    wire logic rd_set;
    wire logic rd_stat;
    wire logic [`IPS_DATA_W-1:0] ctrl_word;
    wire logic [`IPS_DATA_W-1:0] set_word;
    wire logic [`IPS_DATA_W-1:0] stat_word;
    wire logic [`IPS_DATA_W-1:0] rd_word;
    wire logic [3:0] sel_bits;

    // write path: address and data are taken in either order, then one response
    assign aw_take = s_axi_awvalid & awready_q;
    assign w_take = s_axi_wvalid & wready_q;
    assign aw_have = aw_hold_q | aw_take;
    assign w_have = w_hold_q | w_take;
    assign do_write = aw_have & w_have & ~bvalid_q;
    assign aw_hold_d = aw_have & ~do_write;
    assign w_hold_d = w_have & ~do_write;
    assign bvalid_d = do_write | (bvalid_q & ~s_axi_bready);
    // no new address or data is taken while a response is still owed
    assign awready_d = ~aw_hold_d & ~bvalid_d;
    assign wready_d = ~w_hold_d & ~bvalid_d;
    assign awaddr_d = aw_take ? s_axi_awaddr : awaddr_q;
    assign wdata_d = w_take ? s_axi_wdata : wdata_q;
    assign wstrb_d = w_take ? s_axi_wstrb : wstrb_q;
    assign wr_addr = aw_take ? s_axi_awaddr : awaddr_q;
    assign wr_data = w_take ? s_axi_wdata : wdata_q;
    assign wr_strb = w_take ? s_axi_wstrb : wstrb_q;

    // every field lives in byte lane 0; the status word is read-only
    assign wr_ctrl = do_write & (wr_addr == `IPS_OFF_CTRL);
    assign wr_set = do_write & (wr_addr == `IPS_OFF_SET);
    assign bresp_d = do_write ? ((wr_ctrl | wr_set) ? `IPS_RESP_OKAY : `IPS_RESP_SLVERR)
                              : bresp_q;
    assign mode_d = (wr_ctrl & wr_strb[0]) ? ips_mode_e'(wr_data[`IPS_CTRL_MODE_BIT])
                                           : mode_q;
    assign third_d = (wr_set & wr_strb[0])
        ? ips_beh_e'(wr_data[`IPS_SET_THIRD_LSB +: `IPS_SET_FIELD_W]) : third_q;
    assign fourth_d = (wr_set & wr_strb[0])
        ? ips_beh_e'(wr_data[`IPS_SET_FOURTH_LSB +: `IPS_SET_FIELD_W]) : fourth_q;

    // read path: one read at a time, data captured when the address is taken
    assign ar_take = s_axi_arvalid & arready_q;
    assign rvalid_d = ar_take | (rvalid_q & ~s_axi_rready);
    assign arready_d = ~rvalid_d;
    assign rd_ctrl = (s_axi_araddr == `IPS_OFF_CTRL);
    assign rd_set = (s_axi_araddr == `IPS_OFF_SET);
    assign rd_stat = (s_axi_araddr == `IPS_OFF_STAT);
    assign sel_bits = {jog_speed_table_bit_c, jog_speed_table_bit_b,
                       program_table_bit_d, program_table_bit_c};
    assign ctrl_word = `IPS_DATA_W'(mode_q) << `IPS_CTRL_MODE_BIT;
    assign set_word = (`IPS_DATA_W'(third_q) << `IPS_SET_THIRD_LSB)
                    | (`IPS_DATA_W'(fourth_q) << `IPS_SET_FOURTH_LSB);
    assign stat_word = (`IPS_DATA_W'(lvl) << `IPS_STAT_LVL_LSB)
                     | (`IPS_DATA_W'(sel_bits) << `IPS_STAT_SEL_LSB);
    assign rd_word = rd_ctrl ? ctrl_word : rd_set ? set_word
                   : rd_stat ? stat_word : '0;
    assign rdata_d = ar_take ? rd_word : rdata_q;
    assign rresp_d = ar_take ? ((rd_ctrl | rd_set | rd_stat) ? `IPS_RESP_OKAY
                                                             : `IPS_RESP_SLVERR)
                             : rresp_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'h0;
            wready_q <= 1'h0;
            aw_hold_q <= 1'h0;
            w_hold_q <= 1'h0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'h0;
            bresp_q <= `IPS_RESP_OKAY;
        end else begin
            awready_q <= awready_d;
            wready_q <= wready_d;
            aw_hold_q <= aw_hold_d;
            w_hold_q <= w_hold_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'h0;
            rvalid_q <= 1'h0;
            rdata_q <= '0;
            rresp_q <= `IPS_RESP_OKAY;
        end else begin
            arready_q <= arready_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

    // settings take effect at once; a restart is not needed here
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_q <= ips_mode_e'(`IPS_CTRL_RST);
            third_q <= ips_beh_e'(`IPS_SET_RST);
            fourth_q <= ips_beh_e'(`IPS_SET_RST);
        end else begin
            mode_q <= mode_d;
            third_q <= third_d;
            fourth_q <= fourth_d;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    ips_sync u_sync_third (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin(third_input_pin),
        .level(lvl[0])
    );

    ips_sync u_sync_fourth (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin(fourth_input_pin),
        .level(lvl[1])
    );

    ips_chan u_chan_third (
        .aclk(aclk),
        .aresetn(aresetn),
        .level(lvl[0]),
        .beh(third_q),
        .mode(mode_q),
        .prog_bit(program_table_bit_c),
        .jog_bit(jog_speed_table_bit_b)
    );

    ips_chan u_chan_fourth (
        .aclk(aclk),
        .aresetn(aresetn),
        .level(lvl[1]),
        .beh(fourth_q),
        .mode(mode_q),
        .prog_bit(program_table_bit_d),
        .jog_bit(jog_speed_table_bit_c)
    );

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_third_closed: assert property (
        (third_q == IPS_BEH_CLOSED) && (mode_q == IPS_MODE_PROG)
            && $stable(third_q) && $stable(mode_q)
        |-> program_table_bit_c == $past(lvl[0]))
        else $error("third input closed setting gives wrong program bit");

    a_third_open: assert property (
        (third_q == IPS_BEH_OPEN) && (mode_q == IPS_MODE_JOG)
            && $stable(third_q) && $stable(mode_q)
        |-> jog_speed_table_bit_b == !$past(lvl[0]))
        else $error("third input open setting gives wrong jog bit");

    a_third_forced_on: assert property (
        ((third_q == IPS_BEH_ON) && (mode_q == IPS_MODE_PROG)) [*2]
        |-> program_table_bit_c)
        else $error("third input forced on but program bit low");

    a_third_forced_off: assert property (
        third_q == IPS_BEH_OFF
        |=> !program_table_bit_c && !jog_speed_table_bit_b)
        else $error("third input forced off but a bit is high");

    a_mode_jog_route: assert property (
        mode_q == IPS_MODE_JOG
        |=> !program_table_bit_c && !program_table_bit_d)
        else $error("program bit active in jog mode");

    a_mode_prog_route: assert property (
        mode_q == IPS_MODE_PROG
        |=> !jog_speed_table_bit_b && !jog_speed_table_bit_c)
        else $error("jog bit active in program mode");

    a_fourth_closed: assert property (
        (fourth_q == IPS_BEH_CLOSED) && (mode_q == IPS_MODE_JOG)
            && $stable(fourth_q) && $stable(mode_q)
        |-> jog_speed_table_bit_c == $past(lvl[1]))
        else $error("fourth input closed setting gives wrong jog bit");

    a_fourth_open: assert property (
        (fourth_q == IPS_BEH_OPEN) && (mode_q == IPS_MODE_PROG)
            && $stable(fourth_q) && $stable(mode_q)
        |-> program_table_bit_d == !$past(lvl[1]))
        else $error("fourth input open setting gives wrong program bit");

    a_fourth_forced_on: assert property (
        ((fourth_q == IPS_BEH_ON) && (mode_q == IPS_MODE_JOG)) [*2]
        |-> jog_speed_table_bit_c)
        else $error("fourth input forced on but jog bit low");

    a_sync_agree: assert property (
        $changed(lvl[0])
        |-> (lvl[0] == $past(third_input_pin, 4))
            && ($past(third_input_pin, 3) == $past(third_input_pin, 4)))
        else $error("third level changed without settled synchroniser stages");

    a_bresp_hold: assert property (
        s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before it was taken");

    a_rdata_hold: assert property (
        s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data changed before it was taken");

endmodule : ips_top

// ===== tb/ips_contact_model.sv
// ips_contact_model: two switch contacts that feed the input pins
// assumes: bench commands the wanted levels; contacts move off the clock after a delay
`timescale 1ns/1ps
module ips_contact_model (
    input wire logic want_third,
    input wire logic want_fourth,
    input wire logic slow,
    output logic third_pin,
    output logic fourth_pin
);
    // contacts are driven both ways, so the last level always stands
    initial begin
        third_pin = 1'h0;
        fourth_pin = 1'h0;
    end
    // delays are odd fractions of a period so pins never line up with aclk edges
    always @(want_third) third_pin <= #(slow ? 61.3 : 7.1) want_third;
    always @(want_fourth) fourth_pin <= #(slow ? 58.7 : 9.4) want_fourth;
endmodule : ips_contact_model

// ===== tb/input_function_polarity_select_bench.sv
// input_function_polarity_select_bench: register, polarity and routing checks
// assumes: ips_top with AXI4-Lite at 40 MHz, contacts from ips_contact_model
`timescale 1ns/1ps
`include "ips_cfg.svh"
module input_function_polarity_select_bench;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, want3, want4, slow, pin3, pin4;
    logic p_c, p_d, j_b, j_c;
    logic [3:0] awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    int error_cnt, checks_done;

    ips_top u_ips_top (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .third_input_pin(pin3),
        .fourth_input_pin(pin4), .program_table_bit_c(p_c), .program_table_bit_d(p_d),
        .jog_speed_table_bit_b(j_b), .jog_speed_table_bit_c(j_c)
    );
    ips_contact_model u_ips_contact_model (
        .want_third(want3), .want_fourth(want4), .slow(slow),
        .third_pin(pin3), .fourth_pin(pin4)
    );

    initial begin
        aclk = 1'h0;
        forever #12.5 aclk = ~aclk;
    end

    task automatic test_done;
        $display("mismatches %0d, comparisons %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : test_done

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected word at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_word

    task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected response at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_resp

    task automatic cmp_sel(input logic [3:0] got, input logic [3:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected selection at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_sel

    function automatic logic act(input logic [1:0] b, input logic l);
        case (b)
            2'h0: return l;
            2'h1: return ~l;
            2'h2: return 1'h1;
            default: return 1'h0;
        endcase
    endfunction : act

    // order is {jog c, jog b, program d, program c}; the idle mode's pair stays low
    function automatic logic [3:0] exp_sel(input logic m, input logic [1:0] b3, b4,
            input logic l3, l4);
        return m ? {act(b4, l4), act(b3, l3), 2'h0} : {2'h0, act(b4, l4), act(b3, l3)};
    endfunction : exp_sel

    task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
            output logic [1:0] r);
        int n;
        n = 0;
        r = 2'h3;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        while (n < 100) begin
            @(posedge aclk);
            n++;
            if (bvalid === 1'h1) begin
                r = bresp;
                bready <= 1'h0;
                break;
            end
            if (awvalid === 1'h1 && awready === 1'h1) awvalid <= 1'h0;
            if (wvalid === 1'h1 && wready === 1'h1) wvalid <= 1'h0;
        end
        if (n == 100) error_cnt++;
    endtask : axi_write

    task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        r = 2'h3;
        d = 32'hFFFFFFFF;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        while (n < 100) begin
            @(posedge aclk);
            n++;
            if (rvalid === 1'h1) begin
                d = rdata;
                r = rresp;
                rready <= 1'h0;
                break;
            end
            if (arvalid === 1'h1 && arready === 1'h1) arvalid <= 1'h0;
        end
        if (n == 100) error_cnt++;
    endtask : axi_read

    task automatic apply(input logic m, input logic [1:0] b3, b4, input logic l3, l4);
        logic [1:0] r;
        logic [31:0] d;
        axi_write(`IPS_OFF_CTRL, {31'h0, m}, 4'hF, r);
        cmp_resp(r, `IPS_RESP_OKAY);
        axi_write(`IPS_OFF_SET, {28'h0, b4, b3}, 4'hF, r);
        cmp_resp(r, `IPS_RESP_OKAY);
        axi_read(`IPS_OFF_SET, d, r);
        cmp_resp(r, `IPS_RESP_OKAY);
        cmp_word(d, {28'h0, b4, b3});
        want3 <= l3;
        want4 <= l4;
        // slow contact plus three sync stages and the output flop
        repeat (12) @(posedge aclk);
        cmp_sel({j_c, j_b, p_d, p_c}, exp_sel(m, b3, b4, l3, l4));
        axi_read(`IPS_OFF_STAT, d, r);
        cmp_word(d, {26'h0, exp_sel(m, b3, b4, l3, l4), l4, l3});
        cmp_resp(r, `IPS_RESP_OKAY);
    endtask : apply

    initial begin
        repeat (30000) @(posedge aclk);
        error_cnt++;
        test_done();
    end

    initial begin
        logic [1:0] r;
        logic [31:0] d;
        int i;
        {aresetn, awvalid, wvalid, bready, arvalid, rready, want3, want4, slow} = '0;
        {awaddr, araddr, wstrb, wdata} = '0;
        error_cnt = 0;
        checks_done = 0;
        void'($urandom(32'h43BE405C));
        repeat (16) @(posedge aclk);
        aresetn <= 1'h1;
        axi_read(`IPS_OFF_CTRL, d, r);
        cmp_word(d, 32'h0);
        axi_read(`IPS_OFF_SET, d, r);
        cmp_word(d, 32'h0);
        axi_read(4'hC, d, r);
        cmp_resp(r, `IPS_RESP_SLVERR);
        cmp_word(d, 32'h0);
        axi_write(`IPS_OFF_STAT, 32'h3F, 4'hF, r);
        cmp_resp(r, `IPS_RESP_SLVERR);
        axi_write(`IPS_OFF_CTRL, 32'h1, 4'h0, r);
        cmp_resp(r, `IPS_RESP_OKAY);
        axi_read(`IPS_OFF_CTRL, d, r);
        cmp_word(d, 32'h0);
        // a fresh contact closure must not reach the output within two edges
        want3 <= 1'h1;
        wait (pin3 === 1'h1);
        repeat (2) @(posedge aclk);
        #1 cmp_sel({j_c, j_b, p_d, p_c}, 4'h0);
        for (i = 0; i < 8 && p_c !== 1'h1; i++) @(posedge aclk);
        #1 cmp_sel({j_c, j_b, p_d, p_c}, 4'h1);
        for (i = 0; i < 128; i++) begin
            slow <= i[0] ^ i[3];
            apply(i[6], i[5:4], i[3:2], i[1], i[0]);
        end
        for (i = 0; i < 60; i++) begin
            slow <= 1'($urandom % 2);
            apply(1'($urandom % 2), 2'($urandom % 4), 2'($urandom % 4),
                1'($urandom % 2), 1'($urandom % 2));
        end
        test_done();
    end
endmodule : input_function_polarity_select_bench
